// file: logic/acs_defines.vh
// constants for the conversion sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_SAMPLE_CLKS 5'h04
`define ACS_CONV_CLKS 5'h0c
`define ACS_TOTAL_CLKS 5'h10
`define ACS_CNT_RST 5'h00
`define ACS_RES_RST 12'h000
`define ACS_RES_HI 11:8
`define ACS_RES_LO 7:0
`define ACS_HI_PAD 2'h0
`define ACS_RES_W 12
`define ACS_RES_FULL 12'hfff
`define ACS_DIV_W 3
`define ACS_PRE_W 7
`define ACS_ST_IDLE 2'h0
`define ACS_ST_ARMED 2'h1
`define ACS_ST_SAMPLE 2'h2
`define ACS_ST_CONVERT 2'h3
`endif

// file: logic/acs_clk_div.v
// conversion clock divider producing one-cycle ticks
`timescale 1ns/100ps
`include "acs_defines.vh"
module acs_clk_div (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire run_i,
  input wire [`ACS_DIV_W-1:0] sel_i,
  output wire tick_o
);
  reg [`ACS_PRE_W-1:0] cnt_q;
  wire [`ACS_PRE_W-1:0] mask;
  // divide by 2**sel
  assign mask = (7'h01 << sel_i) - 7'h01;
  assign tick_o = run_i && ((cnt_q & mask) == mask);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 7'h00;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt_q <= 7'h00;
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end
endmodule // acs_clk_div

// file: logic/acs_conv_seq.v
// conversion sequencer for the successive-approximation converter
//
// Operation
// RULE1 - a high-then-low pulse on start launches one conversion
// RULE2 - busy flag rises once conversion starts and stays while running
// RULE3 - busy flag falls automatically when conversion finishes
// RULE4 - completion sets irq flag; interrupt raised only when enabled
// RULE5 - software may poll busy flag when interrupt disabled
// RULE6 - conversion clock is system clock divided by two to select power
// RULE7 - software keeps conversion clock period within 0.5 to 10 us
// RULE8 - converter powered only while power enable is high
// RULE9 - software waits settling delay after enabling before starting
// RULE10 - software clears power enable when idle to save power
// RULE11 - sampling lasts exactly four conversion clock periods
// RULE12 - twelve conversion periods follow; sixteen periods in total
// RULE13 - conversion runs in hardware without stalling the program
// RULE14 - result registers hold the result once busy falls
// RULE15 - result is twelve bits, full scale all ones
// RULE16 - start rise aborts and resets; start fall begins sampling
// RULE17 - irq flag stays until software clears it
`timescale 1ns/100ps
`include "acs_defines.vh"
module acs_conv_seq (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire start_i,
  input wire converter_power_enable_i,
  input wire [`ACS_DIV_W-1:0] conv_clock_divider_select_i,
  input wire irq_enable_i,
  input wire irq_clear_i,
  input wire [`ACS_RES_W-1:0] core_result_i,
  input wire core_result_valid_i,
  output wire conv_busy_flag_o,
  output wire irq_flag_o,
  output wire irq_o,
  output wire core_power_o,
  output reg conv_clk_o,
  output reg sample_o,
  output reg convert_o,
  output wire [`ACS_RES_W/2-1:0] result_high_reg_o,
  output wire [7:0] result_low_reg_o
);
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg start_q;
  reg [4:0] cnt_q;
  reg [4:0] cnt_d;
  reg busy_q;
  reg irq_q;
  reg [`ACS_RES_W-1:0] res_q;
  reg [`ACS_RES_W-1:0] cap_q;
  wire tick;
  wire rise;
  wire fall;
  wire running;
  wire done;

  // ----------------------------------------
  // phase decode
  // ----------------------------------------
  function acs_active;
    input [1:0] st;
    begin
      acs_active = (st == `ACS_ST_SAMPLE) || (st == `ACS_ST_CONVERT);
    end
  endfunction

  // ----------------------------------------
  // edge detect and divider
  // ----------------------------------------
  assign rise = start_i && !start_q;
  assign fall = !start_i && start_q;
  assign running = acs_active(state_q);

  acs_clk_div u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .run_i(running),
    .sel_i(conv_clock_divider_select_i),
    .tick_o(tick)
  ); // RULE6

  assign done = (state_q == `ACS_ST_CONVERT) && tick && (cnt_q == `ACS_TOTAL_CLKS - 5'h01); // RULE12

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      `ACS_ST_IDLE: begin
        if (rise) begin
          state_d = `ACS_ST_ARMED;
        end
      end
      `ACS_ST_ARMED: begin
        if (fall && converter_power_enable_i) begin
          state_d = `ACS_ST_SAMPLE; // RULE16
          cnt_d = 5'h00;
        end
      end
      `ACS_ST_SAMPLE: begin
        if (tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == `ACS_SAMPLE_CLKS - 5'h01) begin
            state_d = `ACS_ST_CONVERT; // RULE11
          end
        end
      end
      `ACS_ST_CONVERT: begin
        if (tick) begin
          cnt_d = cnt_q + 5'h01;
          if (done) begin
            state_d = `ACS_ST_IDLE; // RULE12
            cnt_d = 5'h00;
          end
        end
      end
      default: begin
        state_d = `ACS_ST_IDLE;
      end
    endcase
    // abort on rising start or power loss
    if (rise) begin
      state_d = `ACS_ST_ARMED; // RULE16
      cnt_d = 5'h00;
    end else if (!converter_power_enable_i && state_q != `ACS_ST_IDLE) begin
      state_d = `ACS_ST_IDLE; // RULE8
      cnt_d = 5'h00;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= `ACS_ST_IDLE;
      cnt_q <= `ACS_CNT_RST;
      start_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      start_q <= start_i; // RULE1
    end
  end

  // ----------------------------------------
  // busy flag
  // ----------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_q <= 1'b0;
    end else if (ce_i) begin
      busy_q <= acs_active(state_d); // RULE2 RULE3 RULE13
    end
  end

  // ----------------------------------------
  // completion flag, set wins over clear
  // ----------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      if (done) begin
        irq_q <= 1'b1; // RULE4 RULE17
      end else if (irq_clear_i) begin
        irq_q <= 1'b0; // RULE17
      end
    end
  end

  // ----------------------------------------
  // result capture
  // ----------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      res_q <= `ACS_RES_RST;
      cap_q <= `ACS_RES_RST;
    end else if (ce_i) begin
      if (core_result_valid_i && running) begin
        cap_q <= core_result_i; // RULE15
      end
      if (done) begin
        res_q <= (core_result_valid_i) ? core_result_i : cap_q; // RULE14
      end
    end
  end

  // ----------------------------------------
  // conversion clock and phase strobes
  // ----------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_clk_o <= 1'b0;
      sample_o <= 1'b0;
      convert_o <= 1'b0;
    end else if (ce_i) begin
      if (tick) begin
        conv_clk_o <= ~conv_clk_o;
      end else if (!running) begin
        conv_clk_o <= 1'b0;
      end
      sample_o <= (state_d == `ACS_ST_SAMPLE); // RULE11
      convert_o <= (state_d == `ACS_ST_CONVERT); // RULE12
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  assign conv_busy_flag_o = busy_q; // RULE5
  assign irq_flag_o = irq_q;
  assign irq_o = irq_q && irq_enable_i; // RULE4
  assign core_power_o = converter_power_enable_i; // RULE8

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  assign result_high_reg_o = {`ACS_HI_PAD, res_q[`ACS_RES_HI]};
  assign result_low_reg_o = res_q[`ACS_RES_LO];
endmodule // acs_conv_seq

// file: verif/acs_core_model.sv
// analog core stand-in for the conversion sequencer
`timescale 1ns/100ps
module acs_core_model (
  input wire logic convert_i,
  input wire logic power_i,
  input wire logic [11:0] value_i,
  output logic [11:0] result_o,
  output logic valid_o
);
  assign valid_o = convert_i & power_i;
  assign result_o = valid_o ? value_i : ~value_i;
endmodule // acs_core_model

// file: verif/acs_conv_seq_sva.sv
// assertions for the conversion sequencer
`timescale 1ns/100ps
module acs_conv_seq_sva (
  input wire clk_i, rstn_i, ce_i, start_i, converter_power_enable_i, irq_enable_i, irq_clear_i,
  input wire [2:0] conv_clock_divider_select_i,
  input wire conv_busy_flag_o, irq_flag_o, irq_o, core_power_o, sample_o, convert_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire fast = ce_i && converter_power_enable_i && conv_clock_divider_select_i == 3'h0 && !start_i;
  sequence s_sample; sample_o[*4] ##1 (!sample_o && convert_o); endsequence
  sequence s_convert; convert_o[*8] ##1 convert_o[*4] ##1 !conv_busy_flag_o; endsequence
  start_go_a: assert property ($fell(start_i) && ce_i && converter_power_enable_i
    |=> conv_busy_flag_o && sample_o) else $error("no busy after start");
  sample_len_a: assert property ($rose(sample_o) && fast |-> s_sample) else $error("bad sampling");
  conv_len_a: assert property ($rose(convert_o) && fast |-> s_convert) else $error("bad convert");
  done_irq_a: assert property ($fell(convert_o) && converter_power_enable_i && !start_i
    |-> irq_flag_o && !conv_busy_flag_o) else $error("bad completion");
  irq_gate_a: assert property (irq_o == (irq_flag_o && irq_enable_i)) else $error("bad irq");
  power_gate_a: assert property (core_power_o == converter_power_enable_i) else $error("bad power");
  irq_hold_a: assert property (irq_flag_o && !irq_clear_i |=> irq_flag_o) else $error("irq lost");
  irq_clr_a: assert property (irq_flag_o && irq_clear_i && ce_i && !convert_o |=> !irq_flag_o)
    else $error("irq stuck");
  power_abort_a: assert property (ce_i && !converter_power_enable_i |=> !conv_busy_flag_o)
    else $error("busy while off");
endmodule // acs_conv_seq_sva
bind acs_conv_seq acs_conv_seq_sva chk_i (.*);

// file: verif/tb_acs_conv_seq.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module tb_acs_conv_seq;
  logic clk_i = 0, rstn_i = 0, st = 0, pw = 0, ie = 0, ic = 0, ce = 1, pk = 0, vld, busy, fl, irq, cp, ck, sm, cv;
  logic [2:0] sel = 0;
  logic [11:0] val = 0, res;
  logic [5:0] rh;
  logic [7:0] rl;
  int n_errors = 0, n_tests = 0, t = 0, n, nk;
  acs_conv_seq dut (.clk_i, .rstn_i, .ce_i(ce), .start_i(st), .converter_power_enable_i(pw),
    .conv_clock_divider_select_i(sel), .irq_enable_i(ie), .irq_clear_i(ic), .core_result_i(res),
    .core_result_valid_i(vld), .conv_busy_flag_o(busy), .irq_flag_o(fl), .irq_o(irq), .core_power_o(cp),
    .conv_clk_o(ck), .sample_o(sm), .convert_o(cv), .result_high_reg_o(rh), .result_low_reg_o(rl));
  acs_core_model core (.convert_i(cv), .power_i(cp), .value_i(val), .result_o(res), .valid_o(vld));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    t++;
    if (t > 9000) begin n_errors++; complete_run; end
  end
  task cyc(int k); repeat (k) @(posedge clk_i); #1; endtask
  task chk(string s, logic [11:0] a, e);
    n_tests++;
    if (a !== e) begin n_errors++; $display("unexpected %s exp %h seen %h", s, e, a); end
  endtask
  task pulse; st = 1; cyc(1); st = 0; endtask
  task clr; ic = 1; cyc(1); ic = 0; endtask
  task t_div;
    for (int s = 0; s < 8; s++) begin
      clr;
      sel = s;
      val = s ? {s[2:0], 9'h0a5} : 12'hfff;
      n = 0;
      nk = 0;
      pulse;
      repeat (18 << s) begin cyc(1); n += busy; nk += ck & !pk; pk = ck; end
      chk("len", n >> s, 16);
      chk("clk", nk, 8);
      chk("res", {rh[3:0], rl}, val);
      chk("irq", {fl, irq, busy}, 3'h6);
    end
  endtask
  task t_abort;
    sel = 1; pulse; cyc(20); st = 1; cyc(2);
    chk("abort", {busy, fl}, 2'h1);
    st = 0; clr; cyc(39); chk("redo", {busy, fl}, 2'h1);
    clr; ie = 0; pulse; cyc(10); pw = 0; cyc(2);
    chk("off", {busy, cp}, 2'h0);
    pw = 1; cyc(40); chk("noirq", fl, 0);
    pulse; cyc(40); chk("mask", {fl, irq}, 2'h2);
  endtask
  task t_poll;
    clr; pw = 0; pulse; cyc(2);
    chk("refuse", {busy, cp}, 2'h0);
    pw = 1; sel = 4; val = 12'h5a3; n = 0; cyc(8);
    pulse; cyc(1); ce = 0; cyc(50);
    chk("freeze", {busy, sm}, 2'h3);
    ce = 1;
    while (busy === 1'b1 && n < 400) begin cyc(1); n++; end
    chk("poll", n, 256);
    chk("res2", {rh[3:0], rl}, val);
    chk("flag", {fl, irq, busy}, 3'h4);
    pw = 0; cyc(1);
    chk("idle", cp, 0);
  endtask
  task complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    cyc(4); rstn_i = 1; pw = 1; ie = 1; cyc(4);
    t_div;
    t_abort;
    t_poll;
    complete_run;
  end
endmodule // tb_acs_conv_seq
